// ===== dfm_host.sv
// Host model that issues direct commands over APB
`timescale 1ns/1ps
module dfm_host (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer, request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr; // One for a write to any register, zero for a read
        paddr <= {idx[5:0], 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ===== dfm_monitor.sv
// Diagnostic fault monitor with APB register access
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - Oscillator fault raises permanent fail if enabled
// - Comparator mux check fail raises permanent fail
// - Missed watchdog service resets the processor
// - Watchdog reset sets battery status flag
// - Missed completion of both conversions forces watchdog fault
// - RAM corruption forces watchdog reset
// - RAM error inside window enters shutdown
// - Instruction ROM signature fail raises permanent fail
// - Data ROM signature fail raises permanent fail
// - OTP fail loads defaults, FETs, regulator off
// - OTP signature excludes manufacturing, stored status
// - Trim signature fail begins shutdown
// - Status read; one echo after write
// - Safety alert and fault bytes read-only
// - Permanent-fail alert and status bytes read-only
module dfm_monitor import dfm_pkg::*; #(
    parameter int WD_LIMIT = WD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Diagnostic events from pins
    input wire logic oscDeviation,
    input wire logic muxCheckFail,
    input wire logic ramCorrupt,
    // Processor and converter events, same clock
    input wire logic wdService,
    input wire logic adcDone,
    input wire logic ccDone,
    // Boot signature results, same clock
    input wire logic sigValid,
    input wire dfm_sig_t sigResult,
    // Safety flags from protection logic
    input wire logic [47:0] safetyFlags,
    input wire logic [15:0] deviceStatus,
    // Actions
    output logic procReset,
    output logic shutdown,
    output logic fetsOff,
    output logic auxRegOff,
    output logic loadDefaults,
    output logic [7:0] pfStatus
);
    // Whole block state lives in one packed struct.
    // The next value is built in one always_comb and
    // registered in one always_ff, so every output
    // below is a plain flip-flop with no logic behind it.
    // Reset values that are not zero are set in the
    // reset branch from package constants only.
    dfm_reg_t r;
    dfm_reg_t next_r;
    logic wdFault;
    logic ramErr;
    logic [7:0] idx;
    logic access;

    // Zero-extend a byte to a word
    function automatic logic [31:0] byteWord(input logic [7:0] b);
        byteWord = {24'h000000, b};
    endfunction

    // Only the second stage of each synchroniser feeds logic
    assign ramErr = r.syncOsc2[2];
    assign wdFault = (r.wdCnt >= WD_LIMIT[15:0]);
    assign idx = {2'b00, paddr[7:2]};
    assign access = psel && penable && !r.pready;

    // Next-state logic.
    // Order inside the process matters: the state machine
    // runs first, then the runtime permanent fails, then the
    // action outputs that follow the new fail bits, and the
    // register bus last. A bus write to the enables therefore
    // only affects fails seen from the following cycle on.
    // Fail bits are only ever set here, never cleared; the
    // only way back to zero is the synchronous reset.
    // Pin events enter through two flops; the first stage
    // is read by nothing but the second stage.
    // The watchdog counter saturates at the limit so that
    // a stuck fault cannot wrap and hide itself.
    always_comb begin
        next_r = r;
        next_r.syncOsc1 = {ramCorrupt, muxCheckFail, oscDeviation};
        next_r.syncOsc2 = r.syncOsc1;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        unique case (r.state)
            DFM_CHECK: begin
                // Boot checks: wait for the signature engine.
                // Results are taken on the single sigValid cycle;
                // the enables already hold their reset defaults,
                // so memory fails are armed unless software
                // cleared them before the results arrive.
                // A bad trim signature wins over normal start.
                next_r.procReset = 1'b0;
                if (sigValid) begin
                    // OTP signature covers customer data only
                    if (sigResult.iromBad && r.faultEnable[EN_IROM]) begin
                        next_r.pfStatus[PF_IROM] = 1'b1;
                    end
                    if (sigResult.dromBad && r.faultEnable[EN_DROM]) begin
                        next_r.pfStatus[PF_DROM] = 1'b1;
                    end
                    if (sigResult.otpBad) begin
                        next_r.loadDefaults = 1'b1;
                        if (r.faultEnable[EN_OTP]) begin
                            next_r.pfStatus[PF_OTP] = 1'b1;
                        end
                    end
                    if (sigResult.trimBad) begin
                        next_r.state = DFM_SHUT;
                        next_r.shutdown = 1'b1;
                    end else begin
                        next_r.state = DFM_RUN;
                    end
                end
            end
            DFM_RUN: begin
                // Normal operation.
                // The counter clears when the processor services it
                // while at least one conversion completes, and on entry to the reset pulse;
                // a halted processor or both converters stalled
                // let it run into the limit.
                // The RAM window counts cycles since the last
                // watchdog reset and closes by itself.
                // Watchdog counts; service together with either conversion clears it
                if (wdService && (adcDone || ccDone)) begin
                    next_r.wdCnt = 16'h0000;
                end else if (!wdFault) begin
                    next_r.wdCnt = r.wdCnt + 16'h0001;
                end
                if (r.windowOpen) begin
                    if (r.windowCnt >= r.ramWindow) begin
                        next_r.windowOpen = 1'b0;
                    end else begin
                        next_r.windowCnt = r.windowCnt + 16'h0001;
                    end
                end
                if (ramErr && r.windowOpen) begin
                    next_r.state = DFM_SHUT;
                    next_r.shutdown = 1'b1;
                end else if (wdFault || ramErr) begin
                    next_r.state = DFM_RESET;
                    next_r.procReset = 1'b1;
                    next_r.rstCnt = 3'd0;
                    next_r.wdCnt = 16'h0000;
                end
            end
            DFM_RESET: begin
                // Processor reset pulse of fixed length.
                // RAM errors are ignored while it stands; the
                // flag and the RAM window start when it ends,
                // never at its start.
                if (r.rstCnt == 3'(RST_PULSE_CYCLES - 1)) begin
                    next_r.procReset = 1'b0;
                    next_r.wdFlag = 1'b1;
                    next_r.windowOpen = 1'b1;
                    next_r.windowCnt = 16'h0000;
                    next_r.state = DFM_RUN;
                end else begin
                    next_r.rstCnt = r.rstCnt + 3'd1;
                end
            end
            DFM_SHUT: begin
                // Terminal until reset; no further resets,
                // so a broken RAM cannot loop the processor.
                next_r.shutdown = 1'b1;
            end
        endcase
        // Runtime permanent fails, sticky until reset
        if (r.syncOsc2[0] && r.faultEnable[EN_OSC]) begin
            next_r.pfStatus[PF_OSC] = 1'b1;
        end
        if (r.syncOsc2[1] && r.faultEnable[EN_MUX]) begin
            next_r.pfStatus[PF_MUX] = 1'b1;
        end
        // Any permanent fail holds FETs off; only the OTP fail holds the regulator off
        next_r.fetsOff = |next_r.pfStatus;
        next_r.auxRegOff = next_r.pfStatus[PF_OTP];
        // Register bus.
        // Every access gets exactly one wait state: the answer
        // is registered, so pready, prdata and pslverr all come
        // from flops; pready and pslverr stand for one cycle, prdata until the next access.
        // The pready term in access keeps a held request from
        // being taken twice. Read-only and unmapped writes are
        // refused with an error and change nothing.
        // APB access, answered one cycle after the access phase starts
        if (access) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h00000000;
            if (pwrite) begin
                unique case (idx)
                    IDX_CTRL_STATUS: next_r.echoPending = 1'b1;
                    IDX_FAULT_ENABLE: next_r.faultEnable = pwdata[7:0];
                    IDX_RAM_WINDOW: next_r.ramWindow = pwdata[15:0];
                    default: next_r.pslverr = 1'b1;
                endcase
            end else begin
                unique case (idx)
                    IDX_CTRL_STATUS: begin
                        next_r.prdata = r.echoPending ? {16'h0000, WRITE_ECHO} : {16'h0000, deviceStatus};
                        next_r.echoPending = 1'b0;
                    end
                    IDX_SAFE_ALERT_A: next_r.prdata = byteWord(safetyFlags[7:0]);
                    IDX_SAFE_FAULT_A: next_r.prdata = byteWord(safetyFlags[15:8]);
                    IDX_SAFE_ALERT_B: next_r.prdata = byteWord(safetyFlags[23:16]);
                    IDX_SAFE_FAULT_B: next_r.prdata = byteWord(safetyFlags[31:24]);
                    IDX_SAFE_ALERT_C: next_r.prdata = byteWord(safetyFlags[39:32]);
                    IDX_SAFE_FAULT_C: next_r.prdata = byteWord(safetyFlags[47:40]);
                    IDX_PERM_ALERT_A: next_r.prdata = byteWord(r.pfStatus);
                    IDX_PERM_FAULT_A: next_r.prdata = byteWord(r.pfStatus);
                    IDX_PERM_ALERT_B, IDX_PERM_FAULT_B, IDX_PERM_ALERT_C,
                    IDX_PERM_FAULT_C, IDX_PERM_ALERT_D: next_r.prdata = 32'h00000000;
                    IDX_BATT_STATUS: next_r.prdata = {31'h00000000, r.wdFlag};
                    IDX_FAULT_ENABLE: next_r.prdata = byteWord(r.faultEnable);
                    IDX_RAM_WINDOW: next_r.prdata = {16'h0000, r.ramWindow};
                    default: next_r.pslverr = 1'b1;
                endcase
            end
        end
    end

    // State register with synchronous reset.
    // The reset branch assigns constants only; the state
    // machine restarts in the boot check after every reset.
    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r <= '0;
            r.faultEnable <= FAULT_ENABLE_RST;
            r.ramWindow <= RAM_WINDOW_RST;
            r.state <= DFM_CHECK;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign procReset = r.procReset;
    assign shutdown = r.shutdown;
    assign fetsOff = r.fetsOff;
    assign auxRegOff = r.auxRegOff;
    assign loadDefaults = r.loadDefaults;
    assign pfStatus = r.pfStatus;

    // Assertions
    a_osc_pf_set: assert property (@(posedge clk) disable iff (!rst_b)
        r.syncOsc2[0] && r.faultEnable[EN_OSC] |=> r.pfStatus[PF_OSC])
        else $error("oscillator fail not latched");
    a_mux_pf_set: assert property (@(posedge clk) disable iff (!rst_b)
        r.syncOsc2[1] && r.faultEnable[EN_MUX] |=> r.pfStatus[PF_MUX])
        else $error("mux fail not latched");
    a_wd_reset_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_RUN && wdFault && !ramErr |=> procReset [*4])
        else $error("watchdog reset pulse wrong");
    a_wd_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(procReset) && r.state == DFM_RUN |-> r.wdFlag)
        else $error("watchdog flag missing");
    a_ram_shutdown: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_RUN && ramErr && r.windowOpen |=> shutdown && !procReset)
        else $error("ram error in window did not shut down");
    a_trim_shutdown: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_CHECK && sigValid && sigResult.trimBad |=> shutdown)
        else $error("trim fail did not shut down");
    a_pf_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(pfStatus) & ~pfStatus) == 8'h00)
        else $error("permanent fail bit cleared");
    a_otp_actions: assert property (@(posedge clk) disable iff (!rst_b)
        pfStatus[PF_OTP] |=> fetsOff && auxRegOff)
        else $error("otp fail actions missing");
    a_echo_once: assert property (@(posedge clk) disable iff (!rst_b)
        access && !pwrite && idx == IDX_CTRL_STATUS && r.echoPending |=> prdata[15:0] == WRITE_ECHO ##1 !r.echoPending)
        else $error("status echo wrong");
    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_b)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
    c_wd_reset: cover property (@(posedge clk) disable iff (!rst_b) $rose(procReset));
    c_shutdown: cover property (@(posedge clk) disable iff (!rst_b) $rose(shutdown));
    c_echo_read: cover property (@(posedge clk) disable iff (!rst_b) pready && prdata[15:0] == WRITE_ECHO);
    c_otp_fail: cover property (@(posedge clk) disable iff (!rst_b) $rose(loadDefaults));
    c_ram_window: cover property (@(posedge clk) disable iff (!rst_b) r.windowOpen && ramErr);

    // Boot signature checks
    a_irom_pf_set: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_CHECK && sigValid && sigResult.iromBad && r.faultEnable[EN_IROM] |=> pfStatus[PF_IROM])
        else $error("instruction rom fail not latched");
    a_drom_pf_set: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_CHECK && sigValid && sigResult.dromBad && r.faultEnable[EN_DROM] |=> pfStatus[PF_DROM])
        else $error("data rom fail not latched");
    a_otp_defaults: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_CHECK && sigValid && sigResult.otpBad |=> loadDefaults)
        else $error("defaults not loaded");
    a_pf_needs_en: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_CHECK && sigValid && sigResult.iromBad && !r.faultEnable[EN_IROM]
        && !r.pfStatus[PF_IROM] |=> !pfStatus[PF_IROM])
        else $error("disabled fail was latched");

    // Runtime watchdog and RAM checks
    a_wd_counts: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_RUN && !(wdService && (adcDone || ccDone)) && !wdFault && !ramErr
        |=> r.wdCnt == $past(r.wdCnt) + 16'h0001)
        else $error("watchdog counter stalled");
    a_ram_reset: assert property (@(posedge clk) disable iff (!rst_b)
        r.state == DFM_RUN && ramErr && !r.windowOpen |=> procReset && !shutdown)
        else $error("ram error did not reset");
    a_shut_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        shutdown |=> shutdown)
        else $error("shutdown released");

    // Register reads and refusals
    a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        access && !pwrite && idx == IDX_CTRL_STATUS && !r.echoPending
        |=> prdata[15:0] == $past(deviceStatus))
        else $error("status read wrong");
    a_ro_refused: assert property (@(posedge clk) disable iff (!rst_b)
        access && pwrite && idx == IDX_SAFE_ALERT_A |=> pready && pslverr)
        else $error("read-only write not refused");
    a_pf_read: assert property (@(posedge clk) disable iff (!rst_b)
        access && !pwrite && idx == IDX_PERM_FAULT_A |=> prdata[7:0] == $past(r.pfStatus))
        else $error("permanent fail read wrong");
    a_batt_read: assert property (@(posedge clk) disable iff (!rst_b)
        access && !pwrite && idx == IDX_BATT_STATUS |=> prdata[0] == $past(r.wdFlag))
        else $error("battery status read wrong");
    a_pready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        pready |=> !pready)
        else $error("pready held too long");
endmodule

// ===== dfm_monitor_test.sv
// Self-checking bench for the diagnostic fault monitor
`timescale 1ns/1ps
module dfm_monitor_test import dfm_pkg::*;;
    localparam int WDL = 20;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, pfStatus;
    logic [31:0] pwdata, prdata;
    logic oscDeviation, muxCheckFail, ramCorrupt, wdService, adcDone, ccDone, sigValid;
    dfm_sig_t sigResult;
    logic [47:0] safetyFlags;
    logic [15:0] deviceStatus;
    logic procReset, shutdown, fetsOff, auxRegOff, loadDefaults;
    int n_errors = 0;
    int checks_done = 0;
    // Reference model state
    logic [7:0] mEn, mPf;
    logic mWd, mEcho;
    logic [15:0] mWin;

    dfm_monitor #(.WD_LIMIT(WDL)) dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .oscDeviation, .muxCheckFail, .ramCorrupt, .wdService, .adcDone, .ccDone,
        .sigValid, .sigResult, .safetyFlags, .deviceStatus, .procReset, .shutdown, .fetsOff, .auxRegOff,
        .loadDefaults, .pfStatus);
    dfm_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Expected read: bit 32 is the error response
    function automatic logic [32:0] model(input logic [7:0] idx);
        case (idx)
            8'h00: return {1'b0, 16'h0, mEcho ? WRITE_ECHO : deviceStatus};
            8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07: return {25'h0, safetyFlags[(idx - 8'h02) * 8 +: 8]};
            8'h0A, 8'h0B: return {25'h0, mPf};
            8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10: return 33'h0;
            8'h12: return {32'h0, mWd};
            8'h20: return {25'h0, mEn};
            8'h21: return {17'h0, mWin};
            default: return {1'b1, 32'h0};
        endcase
    endfunction

    task automatic rd(input logic [7:0] idx);
        logic [31:0] d;
        logic e;
        logic [32:0] x;
        x = model(idx);
        host.xfer(1'b0, idx, 32'h0, d, e);
        check($sformatf("read %h", idx), d, x[31:0]);
        check($sformatf("rderr %h", idx), {31'h0, e}, {31'h0, x[32]});
        if (idx == 8'h00) mEcho = 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] v, input logic err);
        logic [31:0] d;
        logic e;
        host.xfer(1'b1, idx, v, d, e);
        check($sformatf("wrerr %h", idx), {31'h0, e}, {31'h0, err});
    endtask

    // Reset, optional enable write, then boot signature result
    task automatic boot(input dfm_sig_t s, input logic [7:0] en);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        mEn = FAULT_ENABLE_RST;
        mPf = 8'h00;
        mWd = 1'b0;
        mEcho = 1'b0;
        mWin = RAM_WINDOW_RST;
        if (en != FAULT_ENABLE_RST) begin
            wr(IDX_FAULT_ENABLE, {24'h0, en}, 1'b0);
            mEn = en;
        end
        @(posedge clk);
        sigValid <= 1'b1;
        sigResult <= s;
        @(posedge clk);
        sigValid <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic settle();
        for (int i = 0; i < 40 && pfStatus !== mPf; i++) @(posedge clk);
        check("pfStatus", {24'h0, pfStatus}, {24'h0, mPf});
    endtask

    // Wait for a processor reset pulse and measure it
    task automatic wait_rst();
        int n;
        n = 0;
        for (int i = 0; i < 200 && procReset !== 1'b1; i++) @(posedge clk);
        while (procReset === 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check("procReset len", n, RST_PULSE_CYCLES);
    endtask

    task automatic ram_hit();
        ramCorrupt <= 1'b1;
        repeat (2) @(posedge clk);
        ramCorrupt <= 1'b0;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        oscDeviation = 1'b0;
        muxCheckFail = 1'b0;
        ramCorrupt = 1'b0;
        wdService = 1'b1;
        adcDone = 1'b1;
        ccDone = 1'b1;
        sigValid = 1'b0;
        sigResult = '0;
        void'($urandom(32'h59B76F21));
        safetyFlags = {16'($urandom), $urandom};
        deviceStatus = 16'($urandom);
        boot('0, FAULT_ENABLE_RST);
        settle();
        // Whole map, unmapped holes included
        for (int i = 0; i < 34; i++) rd(8'(i));
        wr(IDX_SAFE_FAULT_A, 32'hFF, 1'b1);
        wr(IDX_PERM_FAULT_A, 32'hFF, 1'b1);
        wr(8'h30, 32'hFF, 1'b1);
        wr(IDX_RAM_WINDOW, 32'h0040, 1'b0);
        mWin = 16'h0040;
        rd(IDX_RAM_WINDOW);
        rd(IDX_SAFE_FAULT_A);
        wr(IDX_CTRL_STATUS, 32'h1234, 1'b0);
        mEcho = 1'b1;
        rd(IDX_CTRL_STATUS);
        rd(IDX_CTRL_STATUS);
        // Oscillator fault while disabled, then enabled
        oscDeviation <= 1'b1;
        repeat (10) @(posedge clk);
        settle();
        oscDeviation <= 1'b0;
        wr(IDX_FAULT_ENABLE, 32'h1F, 1'b0);
        mEn = 8'h1F;
        oscDeviation <= 1'b1;
        mPf = 8'h01;
        settle();
        check("fetsOff", {31'h0, fetsOff}, 32'h1);
        muxCheckFail <= 1'b1;
        mPf = 8'h03;
        settle();
        oscDeviation <= 1'b0;
        muxCheckFail <= 1'b0;
        repeat (10) @(posedge clk);
        settle();
        rd(IDX_PERM_FAULT_A);
        rd(IDX_PERM_ALERT_A);
        // Missed service, then RAM error inside the window
        wdService <= 1'b0;
        wait_rst();
        wdService <= 1'b1;
        mWd = 1'b1;
        rd(IDX_BATT_STATUS);
        ram_hit();
        for (int i = 0; i < 50 && shutdown !== 1'b1; i++) @(posedge clk);
        check("shutdown", {31'h0, shutdown}, 32'h1);
        // RAM error with no recent reset, then stalled conversions
        boot('0, FAULT_ENABLE_RST);
        ram_hit();
        wait_rst();
        check("shutdown", {31'h0, shutdown}, 32'h0);
        adcDone <= 1'b0;
        ccDone <= 1'b0;
        wait_rst();
        adcDone <= 1'b1;
        ccDone <= 1'b1;
        // All boot signatures bad
        boot(4'b1111, FAULT_ENABLE_RST);
        mPf = 8'h1C;
        settle();
        check("actions", {28'h0, loadDefaults, auxRegOff, fetsOff, shutdown}, 32'hF);
        // Memory faults with enables cleared
        boot(4'b1110, 8'h00);
        settle();
        check("actions", {28'h0, loadDefaults, auxRegOff, fetsOff, shutdown}, 32'h8);
        finish_test();
    end
endmodule

// ===== dfm_pkg.sv
// Package of constants and types for the diagnostic fault monitor
package dfm_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_STATUS = 8'h00;
    localparam logic [7:0] IDX_SAFE_ALERT_A = 8'h02;
    localparam logic [7:0] IDX_SAFE_FAULT_A = 8'h03;
    localparam logic [7:0] IDX_SAFE_ALERT_B = 8'h04;
    localparam logic [7:0] IDX_SAFE_FAULT_B = 8'h05;
    localparam logic [7:0] IDX_SAFE_ALERT_C = 8'h06;
    localparam logic [7:0] IDX_SAFE_FAULT_C = 8'h07;
    localparam logic [7:0] IDX_PERM_ALERT_A = 8'h0A;
    localparam logic [7:0] IDX_PERM_FAULT_A = 8'h0B;
    localparam logic [7:0] IDX_PERM_ALERT_B = 8'h0C;
    localparam logic [7:0] IDX_PERM_FAULT_B = 8'h0D;
    localparam logic [7:0] IDX_PERM_ALERT_C = 8'h0E;
    localparam logic [7:0] IDX_PERM_FAULT_C = 8'h0F;
    localparam logic [7:0] IDX_PERM_ALERT_D = 8'h10;
    localparam logic [7:0] IDX_BATT_STATUS = 8'h12;
    // Own registers: fault enables and RAM-fail window
    localparam logic [7:0] IDX_FAULT_ENABLE = 8'h20;
    localparam logic [7:0] IDX_RAM_WINDOW = 8'h21;
    // Fault enable bit positions
    localparam int EN_OSC = 0;
    localparam int EN_MUX = 1;
    localparam int EN_IROM = 2;
    localparam int EN_DROM = 3;
    localparam int EN_OTP = 4;
    localparam logic [7:0] FAULT_ENABLE_RST = 8'h1C;
    // Battery status watchdog flag position
    localparam int BATT_WD_BIT = 0;
    // Value returned once after a status write
    localparam logic [15:0] WRITE_ECHO = 16'hFFA5;
    // Permanent-fail status bit positions
    localparam int PF_OSC = 0;
    localparam int PF_MUX = 1;
    localparam int PF_IROM = 2;
    localparam int PF_DROM = 3;
    localparam int PF_OTP = 4;
    // Watchdog, reset pulse and RAM window timing
    localparam int WD_INTERVAL_US = 100;
    localparam int CLK_KHZ = 40000;
    localparam int WD_CYCLES = WD_INTERVAL_US * CLK_KHZ / 1000;
    localparam int RST_PULSE_CYCLES = 4;
    localparam logic [15:0] RAM_WINDOW_RST = 16'h0100;
    // Power-up sequence states
    typedef enum logic [1:0] {
        DFM_CHECK = 2'b00,
        DFM_RUN = 2'b01,
        DFM_RESET = 2'b11,
        DFM_SHUT = 2'b10
    } dfm_state_t;
    // Results of the boot signature checks
    typedef struct packed {
        logic iromBad;
        logic dromBad;
        logic otpBad;
        logic trimBad;
    } dfm_sig_t;
    // Whole state of the block
    typedef struct packed {
        dfm_state_t state;
        logic [7:0] faultEnable;
        logic [7:0] pfStatus;
        logic [15:0] ramWindow;
        logic [15:0] windowCnt;
        logic windowOpen;
        logic [15:0] wdCnt;
        logic [2:0] rstCnt;
        logic wdFlag;
        logic echoPending;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic procReset;
        logic shutdown;
        logic fetsOff;
        logic auxRegOff;
        logic loadDefaults;
        logic [2:0] syncOsc1;
        logic [2:0] syncOsc2;
    } dfm_reg_t;
endpackage
